// file: design/gpm_pkg.sv
package gpm_pkg;

    // Register byte offsets on the bus.
    localparam logic [11:0] OFF_MODE = 12'h000;
    localparam logic [11:0] OFF_OTYPE = 12'h004;
    localparam logic [11:0] OFF_PULL = 12'h008;
    localparam logic [11:0] OFF_IDATA = 12'h010;
    localparam logic [11:0] OFF_ODATA = 12'h014;
    localparam logic [11:0] OFF_BSC = 12'h018;
    localparam logic [11:0] OFF_AFL = 12'h020;
    localparam logic [11:0] OFF_AFH = 12'h024;
    localparam logic [11:0] OFF_AFSEL = 12'h028;
    localparam logic [11:0] OFF_ASW = 12'h02C;

    // Values after reset.
    localparam logic [31:0] RST_MODE = 32'h0000_0000;
    localparam logic [15:0] RST_OTYPE = 16'h0000;
    localparam logic [31:0] RST_PULL = 32'h0000_0000;
    localparam logic [15:0] RST_ODATA = 16'h0000;
    localparam logic [31:0] RST_AF = 32'h0000_0000;
    localparam logic [31:0] RST_AFSEL = 32'h0000_0000;
    localparam logic [15:0] RST_ASW = 16'h0000;

    // Field layout.
    localparam int unsigned MODE_W = 2;
    localparam int unsigned PULL_W = 2;
    localparam int unsigned AF_W = 4;
    localparam int unsigned AF_NUM = 16;
    localparam int unsigned ANA_W = 2;
    localparam int unsigned AF_PER_REG = 8;
    localparam int unsigned BSC_CLR_POS = 16;

    typedef enum logic [1:0] {
        MODE_IN = 2'b00,
        MODE_OUT = 2'b01,
        MODE_ALT = 2'b10,
        MODE_ANA = 2'b11
    } gpm_mode_t;

    typedef enum logic [1:0] {
        PULL_NONE = 2'b00,
        PULL_UP = 2'b01,
        PULL_DOWN = 2'b10,
        PULL_RSVD = 2'b11
    } gpm_pull_t;

    // Analog function codes carried by the analog function select field.
    localparam logic [1:0] ANA_ADC = 2'b00;
    localparam logic [1:0] ANA_DAC = 2'b01;
    localparam logic [1:0] ANA_OPAMP = 2'b10;
    localparam logic [1:0] ANA_COMP = 2'b11;

endpackage : gpm_pkg

// file: design/gpm_reg_if.sv
`timescale 1ns/10ps
interface gpm_reg_if;
    logic wr_en;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport front (output wr_en, output addr, output wdata, input rdata);
    modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface : gpm_reg_if

// file: design/gpm_pin_cell.sv
`timescale 1ns/10ps
module gpm_pin_cell (
    // Configuration of this pin
    input wire logic [1:0] mode,
    input wire logic otype,
    input wire logic [1:0] pull,
    input wire logic odata,
    input wire logic [3:0] af_sel,
    input wire logic sw_en,
    // Peripheral side
    input wire logic [15:0] af_tx_data,
    input wire logic [15:0] af_tx_en,
    // Pad side
    input wire logic pad_in,
    output logic drv_val,
    output logic drv_oe_n,
    output logic pu_en,
    output logic pd_en,
    output logic st_en,
    output logic din,
    output logic sw_close
);
    logic is_ana;
    logic is_out;
    logic is_alt;
    logic data;
    logic drive;

    always_comb begin
        is_ana = (mode == gpm_pkg::MODE_ANA);
        is_out = (mode == gpm_pkg::MODE_OUT);
        is_alt = (mode == gpm_pkg::MODE_ALT);
        data = is_alt ? af_tx_data[af_sel] : odata;
        drive = is_out | (is_alt & af_tx_en[af_sel]);
        // Open-drain only ever sinks, so a one releases the line.
        drv_oe_n = !(drive & (!data | !otype));
        drv_val = data & !otype;
        pu_en = !is_ana & (pull == gpm_pkg::PULL_UP);
        pd_en = !is_ana & (pull == gpm_pkg::PULL_DOWN);
        st_en = !is_ana;
        din = is_ana ? 1'b0 : pad_in;
        sw_close = is_ana & sw_en;
    end
endmodule : gpm_pin_cell

// file: design/gpm_ahb_front.sv
`timescale 1ns/10ps
module gpm_ahb_front (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Register side
    gpm_reg_if.front rif
);
    typedef struct packed {
        logic wr_pend;
        logic rd_pend;
        logic [11:0] addr;
        logic ready;
        logic [31:0] rdata;
    } gpm_front_t;

    gpm_front_t st_r;
    gpm_front_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.wr_pend = 1'b0;
        if (st_r.rd_pend) begin
            // Wait state lets a write just ahead land before the read mux.
            st_nxt.rd_pend = 1'b0;
            st_nxt.ready = 1'b1;
            st_nxt.rdata = rif.rdata;
        end else if (hsel && htrans[1] && hready) begin
            st_nxt.addr = haddr[11:0];
            st_nxt.wr_pend = hwrite;
            st_nxt.rd_pend = !hwrite;
            st_nxt.ready = hwrite;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= '{default: '0, ready: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rif.wr_en = st_r.wr_pend;
    assign rif.addr = st_r.addr;
    assign rif.wdata = hwdata;
    assign hrdata = st_r.rdata;
    assign hreadyout = st_r.ready;
    assign hresp = 1'b0;
endmodule : gpm_ahb_front

// file: design/gpm_top.sv
`timescale 1ns/10ps
module gpm_top #(
    parameter int unsigned N_PINS = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pads
    input wire logic [N_PINS-1:0] pad_in,
    output logic [N_PINS-1:0] pad_out,
    output logic [N_PINS-1:0] pad_oe_n,
    output logic [N_PINS-1:0] pad_pu_en,
    output logic [N_PINS-1:0] pad_pd_en,
    output logic [N_PINS-1:0] pad_st_en,
    // Alternate function peripherals
    input wire logic [N_PINS*16-1:0] af_tx_data,
    input wire logic [N_PINS*16-1:0] af_tx_en,
    output logic [N_PINS-1:0] af_rx_data,
    // Analog switch
    output logic [N_PINS-1:0] ana_sw_close,
    output logic [N_PINS*2-1:0] ana_func_sel
);
    localparam int unsigned NP = N_PINS;

    if (N_PINS < 1 || N_PINS > 16) begin : g_bad_pins
        $error("N_PINS must lie between 1 and 16");
    end

    typedef struct packed {
        logic [31:0] mode;
        logic [15:0] otype;
        logic [31:0] pull;
        logic [15:0] odata;
        logic [31:0] afl;
        logic [31:0] afh;
        logic [31:0] afsel;
        logic [15:0] asw;
        logic [15:0] idata;
        logic [15:0] p_out;
        logic [15:0] p_oe_n;
        logic [15:0] p_pu;
        logic [15:0] p_pd;
        logic [15:0] p_st;
        logic [15:0] sw;
        logic [31:0] func;
    } gpm_regs_t;

    gpm_regs_t st_r;
    gpm_regs_t st_nxt;

    gpm_reg_if rif ();

    // Cell results, one bit per pin.
    logic [15:0] c_val;
    logic [15:0] c_oe_n;
    logic [15:0] c_pu;
    logic [15:0] c_pd;
    logic [15:0] c_st;
    logic [15:0] c_din;
    logic [15:0] c_sw;
    logic [15:0] pin_mask;
    logic [31:0] pin_mask2;

    // Word address decode shared by the write and read paths.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a[11:2] == o[11:2]);
    endfunction : hit

    gpm_ahb_front u_front (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .rif(rif.front)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_pin
            if (gi < NP) begin : g_used
                logic [3:0] sel;
                // Pins 0-7 take their selector from the low word, 8-15 high.
                assign sel = (gi < 8) ? st_r.afl[(gi%8)*4 +: 4]
                                      : st_r.afh[(gi%8)*4 +: 4];
                gpm_pin_cell u_cell (
                    .mode(st_r.mode[gi*2 +: 2]),
                    .otype(st_r.otype[gi]),
                    .pull(st_r.pull[gi*2 +: 2]),
                    .odata(st_r.odata[gi]),
                    .af_sel(sel),
                    .sw_en(st_r.asw[gi]),
                    .af_tx_data(af_tx_data[gi*16 +: 16]),
                    .af_tx_en(af_tx_en[gi*16 +: 16]),
                    .pad_in(pad_in[gi]),
                    .drv_val(c_val[gi]),
                    .drv_oe_n(c_oe_n[gi]),
                    .pu_en(c_pu[gi]),
                    .pd_en(c_pd[gi]),
                    .st_en(c_st[gi]),
                    .din(c_din[gi]),
                    .sw_close(c_sw[gi])
                );
                assign pin_mask[gi] = 1'b1;
                assign pin_mask2[gi*2 +: 2] = 2'b11;
            end else begin : g_unused
                assign c_val[gi] = 1'b0;
                assign c_oe_n[gi] = 1'b1;
                assign c_pu[gi] = 1'b0;
                assign c_pd[gi] = 1'b0;
                assign c_st[gi] = 1'b0;
                assign c_din[gi] = 1'b0;
                assign c_sw[gi] = 1'b0;
                assign pin_mask[gi] = 1'b0;
                assign pin_mask2[gi*2 +: 2] = 2'b00;
            end
        end
    endgenerate

    // Register writes and per-cycle sampling.
    always_comb begin
        st_nxt = st_r;
        if (rif.wr_en) begin
            if (hit(rif.addr, gpm_pkg::OFF_MODE)) begin
                st_nxt.mode = rif.wdata & pin_mask2;
            end
            if (hit(rif.addr, gpm_pkg::OFF_OTYPE)) begin
                st_nxt.otype = rif.wdata[15:0] & pin_mask;
            end
            if (hit(rif.addr, gpm_pkg::OFF_PULL)) begin
                st_nxt.pull = rif.wdata & pin_mask2;
            end
            if (hit(rif.addr, gpm_pkg::OFF_ODATA)) begin
                st_nxt.odata = rif.wdata[15:0] & pin_mask;
            end
            if (hit(rif.addr, gpm_pkg::OFF_BSC)) begin
                // Set wins when one write sets and clears the same bit.
                st_nxt.odata = ((st_r.odata
                    & ~rif.wdata[gpm_pkg::BSC_CLR_POS +: 16])
                    | rif.wdata[15:0]) & pin_mask;
            end
            if (hit(rif.addr, gpm_pkg::OFF_AFL)) begin
                st_nxt.afl = rif.wdata;
            end
            if (hit(rif.addr, gpm_pkg::OFF_AFH)) begin
                st_nxt.afh = rif.wdata;
            end
            if (hit(rif.addr, gpm_pkg::OFF_AFSEL)) begin
                st_nxt.afsel = rif.wdata & pin_mask2;
            end
            if (hit(rif.addr, gpm_pkg::OFF_ASW)) begin
                st_nxt.asw = rif.wdata[15:0] & pin_mask;
            end
        end
        st_nxt.idata = c_din;
        st_nxt.p_out = c_val;
        st_nxt.p_oe_n = c_oe_n;
        st_nxt.p_pu = c_pu;
        st_nxt.p_pd = c_pd;
        st_nxt.p_st = c_st;
        st_nxt.sw = c_sw;
        st_nxt.func = st_r.afsel;
    end

    // Read mux, sampled by the bus front during its wait state.
    always_comb begin
        rif.rdata = 32'h0000_0000;
        if (hit(rif.addr, gpm_pkg::OFF_MODE)) begin
            rif.rdata = st_r.mode;
        end else if (hit(rif.addr, gpm_pkg::OFF_OTYPE)) begin
            rif.rdata = {16'h0000, st_r.otype};
        end else if (hit(rif.addr, gpm_pkg::OFF_PULL)) begin
            rif.rdata = st_r.pull;
        end else if (hit(rif.addr, gpm_pkg::OFF_IDATA)) begin
            rif.rdata = {16'h0000, st_r.idata};
        end else if (hit(rif.addr, gpm_pkg::OFF_ODATA)) begin
            rif.rdata = {16'h0000, st_r.odata};
        end else if (hit(rif.addr, gpm_pkg::OFF_AFL)) begin
            rif.rdata = st_r.afl;
        end else if (hit(rif.addr, gpm_pkg::OFF_AFH)) begin
            rif.rdata = st_r.afh;
        end else if (hit(rif.addr, gpm_pkg::OFF_AFSEL)) begin
            rif.rdata = st_r.afsel;
        end else if (hit(rif.addr, gpm_pkg::OFF_ASW)) begin
            rif.rdata = {16'h0000, st_r.asw};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r.mode <= gpm_pkg::RST_MODE;
            st_r.otype <= gpm_pkg::RST_OTYPE;
            st_r.pull <= gpm_pkg::RST_PULL;
            st_r.odata <= gpm_pkg::RST_ODATA;
            st_r.afl <= gpm_pkg::RST_AF;
            st_r.afh <= gpm_pkg::RST_AF;
            st_r.afsel <= gpm_pkg::RST_AFSEL;
            st_r.asw <= gpm_pkg::RST_ASW;
            st_r.idata <= 16'h0000;
            st_r.p_out <= 16'h0000;
            st_r.p_oe_n <= 16'hFFFF;
            st_r.p_pu <= 16'h0000;
            st_r.p_pd <= 16'h0000;
            st_r.p_st <= 16'h0000;
            st_r.sw <= 16'h0000;
            st_r.func <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pad_out = st_r.p_out[NP-1:0];
    assign pad_oe_n = st_r.p_oe_n[NP-1:0];
    assign pad_pu_en = st_r.p_pu[NP-1:0];
    assign pad_pd_en = st_r.p_pd[NP-1:0];
    assign pad_st_en = st_r.p_st[NP-1:0];
    assign af_rx_data = st_r.idata[NP-1:0];
    assign ana_sw_close = st_r.sw[NP-1:0];
    assign ana_func_sel = st_r.func[NP*2-1:0];

endmodule : gpm_top

// file: verification/gpm_top_assertions.sv
`timescale 1ns/10ps
module gpm_top_chk #(
    parameter int unsigned N_PINS = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pads and peripherals
    input wire logic [N_PINS-1:0] pad_in,
    input wire logic [N_PINS-1:0] pad_oe_n,
    input wire logic [N_PINS-1:0] pad_pu_en,
    input wire logic [N_PINS-1:0] pad_pd_en,
    input wire logic [N_PINS-1:0] pad_st_en,
    input wire logic [N_PINS-1:0] af_rx_data,
    input wire logic [N_PINS-1:0] ana_sw_close
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic rd_ap;
    logic wr_ap;
    assign rd_ap = hsel && htrans[1] && hready && !hwrite;
    assign wr_ap = hsel && htrans[1] && hready && hwrite;

    chk_read_wait: assert property (
        rd_ap |=> !hreadyout ##1 hreadyout)
        else $error("read wait cycle wrong");
    chk_ready_cause: assert property (
        !hreadyout |-> $past(rd_ap))
        else $error("wait cycle without a read");
    chk_resp_okay: assert property (
        rd_ap || wr_ap |=> !hresp)
        else $error("bus response not okay");
    chk_pull_excl: assert property (
        (pad_pu_en & pad_pd_en) == '0)
        else $error("both pulls on");
    chk_input_sample: assert property (
        af_rx_data == ($past(pad_in) & pad_st_en))
        else $error("input sample wrong");
    chk_ana_quiet: assert property (
        (~pad_st_en & (pad_pu_en | pad_pd_en | ~pad_oe_n)) == '0)
        else $error("analog pin not quiet");
    chk_switch_ana: assert property (
        (ana_sw_close & pad_st_en) == '0)
        else $error("switch closed outside analog");
    chk_cfg_quiet: assert property (
        $past(rst_n, 3) && ($changed(pad_pu_en) || $changed(pad_pd_en)
        || $changed(pad_st_en)) |-> $past(wr_ap, 2) || $past(wr_ap, 3))
        else $error("pad setup changed without a write");
    chk_switch_quiet: assert property (
        $past(rst_n, 3) && $changed(ana_sw_close)
        |-> $past(wr_ap, 2) || $past(wr_ap, 3))
        else $error("switch changed without a write");
endmodule : gpm_top_chk

bind gpm_top gpm_top_chk #(.N_PINS(N_PINS)) i_gpm_top_chk (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .pad_in(pad_in), .pad_oe_n(pad_oe_n),
    .pad_pu_en(pad_pu_en), .pad_pd_en(pad_pd_en), .pad_st_en(pad_st_en),
    .af_rx_data(af_rx_data), .ana_sw_close(ana_sw_close));

// file: verification/gpm_pad_model.sv
`timescale 1ns/10ps
module gpm_pad_model #(
    parameter int unsigned N_PINS = 16
) (
    // Clock
    input wire logic core_clk,
    // Pad controls from the block
    input wire logic [N_PINS-1:0] pad_out,
    input wire logic [N_PINS-1:0] pad_oe_n,
    input wire logic [N_PINS-1:0] pad_pu_en,
    input wire logic [N_PINS-1:0] pad_pd_en,
    // Board drivers
    input wire logic [N_PINS-1:0] ext_en,
    input wire logic [N_PINS-1:0] ext_val,
    // Line level
    output logic [N_PINS-1:0] pad_in
);
    logic noise_r = 1'b0;
    // A floating line has no defined level, so it flips every cycle.
    always @(posedge core_clk) noise_r <= ~noise_r;
    always_comb begin
        for (int i = 0; i < N_PINS; i++) begin
            if (!pad_oe_n[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pad_pu_en[i] ^ pad_pd_en[i]) begin
                pad_in[i] = pad_pu_en[i];
            end else begin
                pad_in[i] = noise_r;
            end
        end
    end
endmodule : gpm_pad_model

// file: verification/tb.sv
`timescale 1ns/10ps
module tb;
    localparam int unsigned NP = 16;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [NP-1:0] pad_in, pad_out, pad_oe_n, pad_pu_en, pad_pd_en;
    logic [NP-1:0] pad_st_en, af_rx_data, ana_sw_close;
    logic [NP-1:0] ext_en = '0;
    logic [NP-1:0] ext_val = '0;
    logic [NP*16-1:0] af_tx_data = '0;
    logic [NP*16-1:0] af_tx_en = '0;
    logic [NP*2-1:0] ana_func_sel;
    int n_errors = 0;
    int checked = 0;

    gpm_top #(.N_PINS(NP)) i_gpm_top (.core_clk(core_clk), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hsize(3'b010),
        .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pu_en(pad_pu_en), .pad_pd_en(pad_pd_en),
        .pad_st_en(pad_st_en), .af_tx_data(af_tx_data),
        .af_tx_en(af_tx_en), .af_rx_data(af_rx_data),
        .ana_sw_close(ana_sw_close), .ana_func_sel(ana_func_sel));
    gpm_pad_model #(.N_PINS(NP)) i_gpm_pad_model (.core_clk(core_clk),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pu_en(pad_pu_en),
        .pad_pd_en(pad_pd_en), .ext_en(ext_en), .ext_val(ext_val),
        .pad_in(pad_in));

    initial forever #20 core_clk = ~core_clk;

    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Waits for a rising edge that samples hready high and takes hrdata there.
    task automatic rdy(output logic [31:0] d);
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : rdy

    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        logic [31:0] x;
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0_0000, a};
        hwrite <= w;
        rdy(x);
        htrans <= 2'b00;
        hwdata <= wd;
        rdy(rd);
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rchk(input string nm, input logic [11:0] a,
                        input logic [31:0] e);
        logic [31:0] d;
        bus(1'b0, a, 32'h0000_0000, d);
        chk(nm, e, d);
    endtask : rchk

    // Ends on a rising edge, so stimulus that follows stays edge aligned.
    task automatic settle;
        repeat (4) @(posedge core_clk);
    endtask : settle

    task automatic t_reset;
        logic [11:0] offs [8] = '{gpm_pkg::OFF_MODE, gpm_pkg::OFF_OTYPE,
            gpm_pkg::OFF_PULL, gpm_pkg::OFF_ODATA, gpm_pkg::OFF_AFL,
            gpm_pkg::OFF_AFH, gpm_pkg::OFF_AFSEL, gpm_pkg::OFF_ASW};
        foreach (offs[i]) rchk("reset value", offs[i], 32'h0000_0000);
        chk("oe_n", 32'h0000_FFFF, 32'(pad_oe_n));
        wr(12'h030, 32'hFFFF_FFFF);
        rchk("unmapped", 12'h030, 32'h0000_0000);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_input;
        wr(gpm_pkg::OFF_PULL, 32'hE4E4_E4E4);
        rchk("pull", gpm_pkg::OFF_PULL, 32'hE4E4_E4E4);
        settle;
        chk("pu", 32'h0000_2222, 32'(pad_pu_en));
        chk("pd", 32'h0000_4444, 32'(pad_pd_en));
        chk("st", 32'h0000_FFFF, 32'(pad_st_en));
        chk("oe_n", 32'h0000_FFFF, 32'(pad_oe_n));
        ext_en <= '1;
        ext_val <= 16'h3C5A;
        settle;
        chk("rx", 32'h0000_3C5A, 32'(af_rx_data));
        wr(gpm_pkg::OFF_IDATA, 32'h0000_0000);
        rchk("idata", gpm_pkg::OFF_IDATA, 32'h0000_3C5A);
        ext_en <= '0;
        $display("t_input done");
    endtask : t_input

    task automatic t_output;
        wr(gpm_pkg::OFF_PULL, 32'h5555_5555);
        wr(gpm_pkg::OFF_ODATA, 32'h0000_A5A5);
        wr(gpm_pkg::OFF_OTYPE, 32'h0000_FF00);
        wr(gpm_pkg::OFF_MODE, 32'h5555_5555);
        settle;
        chk("oe_n", 32'h0000_A500, 32'(pad_oe_n));
        chk("drive", 32'h0000_00A5, 32'(pad_out & ~pad_oe_n));
        rchk("idata", gpm_pkg::OFF_IDATA, 32'h0000_A5A5);
        wr(gpm_pkg::OFF_BSC, 32'h0001_0002);
        wr(gpm_pkg::OFF_BSC, 32'h0008_0008);
        rchk("odata", gpm_pkg::OFF_ODATA, 32'h0000_A5AE);
        rchk("bsc", gpm_pkg::OFF_BSC, 32'h0000_0000);
        wr(gpm_pkg::OFF_MODE, 32'h0000_0000);
        wr(gpm_pkg::OFF_MODE, 32'h5555_5555);
        settle;
        chk("drive", 32'h0000_00AE, 32'(pad_out & ~pad_oe_n));
        $display("t_output done");
    endtask : t_output

    task automatic t_alt;
        logic [NP*16-1:0] en;
        logic [NP*16-1:0] dat;
        en = '0;
        dat = '1;
        for (int p = 0; p < NP; p++) begin
            en[p*16+p] = 1'b1;
            dat[p*16+p] = p[0];
        end
        af_tx_en <= en;
        af_tx_data <= dat;
        wr(gpm_pkg::OFF_AFL, 32'h7654_3210);
        wr(gpm_pkg::OFF_AFH, 32'hFEDC_BA98);
        rchk("afl", gpm_pkg::OFF_AFL, 32'h7654_3210);
        rchk("afh", gpm_pkg::OFF_AFH, 32'hFEDC_BA98);
        wr(gpm_pkg::OFF_MODE, 32'hAAAA_AAAA);
        settle;
        chk("oe_n", 32'h0000_AA00, 32'(pad_oe_n));
        chk("drive", 32'h0000_00AA, 32'(pad_out & ~pad_oe_n));
        chk("rx", 32'h0000_AAAA, 32'(af_rx_data));
        wr(gpm_pkg::OFF_AFL, 32'h0000_0000);
        settle;
        chk("oe_n", 32'h0000_AAFE, 32'(pad_oe_n));
        af_tx_en <= '0;
        $display("t_alt done");
    endtask : t_alt

    task automatic t_analog;
        ext_en <= '1;
        ext_val <= '1;
        wr(gpm_pkg::OFF_AFSEL, 32'h1B1B_1B1B);
        wr(gpm_pkg::OFF_ASW, 32'h0000_00F0);
        wr(gpm_pkg::OFF_MODE, 32'h0000_0300);
        settle;
        chk("sw", 32'h0000_0010, 32'(ana_sw_close));
        chk("func", 32'h1B1B_1B1B, 32'(ana_func_sel));
        chk("pu", 32'h0000_FFEF, 32'(pad_pu_en));
        rchk("idata", gpm_pkg::OFF_IDATA, 32'h0000_FFEF);
        wr(gpm_pkg::OFF_MODE, 32'hFFFF_FFFF);
        settle;
        chk("st", 32'h0000_0000, 32'(pad_st_en));
        chk("oe_n", 32'h0000_FFFF, 32'(pad_oe_n));
        chk("rx", 32'h0000_0000, 32'(af_rx_data));
        chk("sw", 32'h0000_00F0, 32'(ana_sw_close));
        rchk("idata", gpm_pkg::OFF_IDATA, 32'h0000_0000);
        wr(gpm_pkg::OFF_ASW, 32'h0000_0000);
        settle;
        chk("sw", 32'h0000_0000, 32'(ana_sw_close));
        ext_en <= '0;
        $display("t_analog done");
    endtask : t_analog

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        t_input;
        t_output;
        t_alt;
        t_analog;
        close_out;
    end

    initial begin
        #200000;
        n_errors++;
        $display("watchdog expired");
        close_out;
    end
endmodule : tb
